// >>> rtl/ssp_pkg.sv
// Package for the serial port: register map, field layout, reset values, types
// Behaviour
// - Sleep as master resets baud generator
// - Sleep as master stops shifter, no resume
// - Master transfer at sleep is abandoned
// - Slave keeps shifting through sleep
// - Slave word end sets receive full, event
// - Event with enable raises wake request
// - Registers kept across sleep
// - Status bit 13 selects idle behaviour
// - Idle halt bit one stops both roles, master as in sleep
// - Control one field layout down bit 0
// - One buffer address: write transmit, read receive
// - Unimplemented bits read zero
// - All registers reset to zero
// - Overrun flag blocks reception until cleared
// - Master emits 8 or 16 clocks, framed continuous
// - Receive and transmit DMA requests
// - Shift clock is clock over twice the prescale product
package ssp_pkg;
    localparam logic [31:0] ADDR_STAT = 32'h0000_0000;
    localparam logic [31:0] ADDR_CON1 = 32'h0000_0004;
    localparam logic [31:0] ADDR_CON2 = 32'h0000_0008;
    localparam logic [31:0] ADDR_BUF  = 32'h0000_000C;
    localparam logic [31:0] ADDR_EVT  = 32'h0000_0010;

    localparam int STAT_ON   = 15;
    localparam int STAT_IDLE = 13;
    localparam int STAT_ROV  = 6;
    localparam int STAT_TBF  = 1;
    localparam int STAT_RBF  = 0;

    localparam int CON2_FRM  = 15;
    localparam int CON2_FSD  = 14;
    localparam int CON2_FPOL = 13;
    localparam int CON2_FDLY = 1;

    localparam int EVT_FLAG = 0;
    localparam int EVT_EN   = 1;

    localparam logic [15:0] STAT_MASK = 16'hA043;
    localparam logic [15:0] CON1_MASK = 16'h1FFF;
    localparam logic [15:0] CON2_MASK = 16'hE002;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [4:0]  BITS_8    = 5'h08;
    localparam logic [4:0]  BITS_16   = 5'h10;

    typedef struct packed {
        logic       clock_output_disable;
        logic       data_output_disable;
        logic       word_width_select;
        logic       sample_phase;
        logic       clock_edge;
        logic       select_pin_enable;
        logic       clock_polarity;
        logic       master_role_enable;
        logic [2:0] secondary_divide;
        logic [1:0] primary_divide;
    } ssp_con1_s;

    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_SHIFT = 2'b01,
        SSP_DONE  = 2'b11
    } ssp_state_e;
endpackage

// >>> rtl/ssp_top.sv
// Serial port core with AHB-Lite register slave, power-mode handling and DMA requests
`timescale 1ns/100ps
module ssp_top (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sleep_req,
    input  wire logic        idle_req,
    output logic             wake_req,
    output logic             rx_dma_req,
    output logic             tx_dma_req,
    input  wire logic        shift_clock_pin_i,
    output logic             shift_clock_pin_o,
    output logic             shift_clock_pin_oe,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        ss_n_i
);
    // Local names for the shared map and types
    localparam logic [31:0] ADDR_STAT = ssp_pkg::ADDR_STAT;
    localparam logic [31:0] ADDR_CON1 = ssp_pkg::ADDR_CON1;
    localparam logic [31:0] ADDR_CON2 = ssp_pkg::ADDR_CON2;
    localparam logic [31:0] ADDR_BUF  = ssp_pkg::ADDR_BUF;
    localparam logic [31:0] ADDR_EVT  = ssp_pkg::ADDR_EVT;
    localparam int          STAT_ON   = ssp_pkg::STAT_ON;
    localparam int          STAT_IDLE = ssp_pkg::STAT_IDLE;
    localparam int          STAT_ROV  = ssp_pkg::STAT_ROV;
    localparam int          STAT_TBF  = ssp_pkg::STAT_TBF;
    localparam int          STAT_RBF  = ssp_pkg::STAT_RBF;
    localparam int          CON2_FRM  = ssp_pkg::CON2_FRM;
    localparam int          EVT_FLAG  = ssp_pkg::EVT_FLAG;
    localparam int          EVT_EN    = ssp_pkg::EVT_EN;
    localparam logic [15:0] STAT_MASK = ssp_pkg::STAT_MASK;
    localparam logic [15:0] CON2_MASK = ssp_pkg::CON2_MASK;
    localparam logic [15:0] REG_RESET = ssp_pkg::REG_RESET;
    localparam logic [4:0]  BITS_8    = ssp_pkg::BITS_8;
    localparam logic [4:0]  BITS_16   = ssp_pkg::BITS_16;
    typedef ssp_pkg::ssp_con1_s  ssp_con1_s;
    typedef ssp_pkg::ssp_state_e ssp_state_e;
    localparam ssp_state_e  SSP_IDLE  = ssp_pkg::SSP_IDLE;
    localparam ssp_state_e  SSP_SHIFT = ssp_pkg::SSP_SHIFT;
    localparam ssp_state_e  SSP_DONE  = ssp_pkg::SSP_DONE;
    logic [15:0]        stat_r;
    ssp_con1_s          con1_r;
    logic [15:0]        con2_r;
    logic [15:0]        rxbuf_r;
    logic [15:0]        txbuf_r;
    logic [15:0]        sr_r;
    logic [4:0]         cnt_r;
    logic [8:0]         div_r;
    logic               sck_r;
    logic               sck_in_r;
    logic               ph_r;
    logic               evt_flag_r;
    logic               evt_en_r;
    ssp_state_e         st_r;
    logic               wr_r;
    logic               rd_r;
    logic [31:0]        a_r;
    logic               word_done;
    logic               tx_load;
    logic               halt;
    logic               on;
    logic               master;
    logic               framed;
    logic [8:0]         div_max;
    logic               tick;
    logic               s_rise;
    logic               s_fall;
    logic               shift_edge;
    logic               sample_edge;
    logic               bus_wr_buf;
    logic               bus_rd_buf;
    logic [4:0]         nbits;
    logic               rx_store;

    function automatic logic [8:0] pre_ratio(input logic [1:0] p, input logic [2:0] s);
        logic [8:0] pr;
        logic [8:0] sc;
        pr = 9'h001 << {p ^ 2'h3, 1'b0};
        sc = 9'h008 - {6'h00, s};
        return 9'((pr * sc) - 9'h001);
    endfunction

    assign on         = stat_r[STAT_ON];
    assign master     = con1_r.master_role_enable;
    assign framed     = con2_r[CON2_FRM];
    // Master stops in sleep; either role stops in idle with halt bit set
    assign halt       = (sleep_req && master) || (idle_req && stat_r[STAT_IDLE]);
    assign div_max    = pre_ratio(con1_r.primary_divide, con1_r.secondary_divide);
    assign nbits      = con1_r.word_width_select ? BITS_16 : BITS_8;
    assign bus_wr_buf = wr_r && (a_r == ADDR_BUF);
    assign bus_rd_buf = rd_r && (a_r == ADDR_BUF);

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            a_r  <= 32'h0000_0000;
        end else if (hready) begin
            wr_r <= hsel && htrans[1] && hwrite;
            rd_r <= hsel && htrans[1] && !hwrite;
            a_r  <= haddr;
        end else begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                if (haddr == ADDR_STAT) begin
                    hrdata <= {16'h0000, stat_r & STAT_MASK};
                end else if (haddr == ADDR_CON1) begin
                    hrdata <= {16'h0000, 3'h0, con1_r};
                end else if (haddr == ADDR_CON2) begin
                    hrdata <= {16'h0000, con2_r & CON2_MASK};
                end else if (haddr == ADDR_BUF) begin
                    hrdata <= {16'h0000, rxbuf_r};
                end else if (haddr == ADDR_EVT) begin
                    hrdata <= {30'h0000_0000, evt_en_r, evt_flag_r};
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Control registers are never touched by sleep or idle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            con1_r   <= ssp_con1_s'(REG_RESET[12:0]);
            con2_r   <= REG_RESET;
            evt_en_r <= 1'b0;
        end else if (wr_r) begin
            if (a_r == ADDR_CON1) begin
                con1_r <= ssp_con1_s'(hwdata[12:0]);
            end else if (a_r == ADDR_CON2) begin
                con2_r <= hwdata[15:0] & CON2_MASK;
            end else if (a_r == ADDR_EVT) begin
                evt_en_r <= hwdata[EVT_EN];
            end
        end
    end

    // Status: hardware set wins over software clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stat_r <= REG_RESET;
        end else begin
            if (wr_r && a_r == ADDR_STAT) begin
                stat_r[STAT_ON]   <= hwdata[STAT_ON];
                stat_r[STAT_IDLE] <= hwdata[STAT_IDLE];
                if (!hwdata[STAT_ROV]) begin
                    stat_r[STAT_ROV] <= 1'b0;
                end
            end
            if (bus_wr_buf) begin
                stat_r[STAT_TBF] <= 1'b1;
            end else if (tx_load) begin
                stat_r[STAT_TBF] <= 1'b0;
            end
            if (word_done && stat_r[STAT_RBF] && !bus_rd_buf) begin
                stat_r[STAT_ROV] <= 1'b1;
            end else if (word_done && !stat_r[STAT_ROV]) begin
                stat_r[STAT_RBF] <= 1'b1;
            end else if (bus_rd_buf) begin
                stat_r[STAT_RBF] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rxbuf_r <= REG_RESET;
            txbuf_r <= REG_RESET;
        end else begin
            if (bus_wr_buf) begin
                txbuf_r <= hwdata[15:0];
            end
            // New word dropped while overrun or unread
            if (rx_store) begin
                rxbuf_r <= con1_r.word_width_select ? sr_r : {8'h00, sr_r[7:0]};
            end
        end
    end

    // Event flag: set by receive completion, cleared by writing zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            evt_flag_r <= 1'b0;
        end else if (rx_store) begin
            evt_flag_r <= 1'b1;
        end else if (wr_r && a_r == ADDR_EVT && !hwdata[EVT_FLAG]) begin
            evt_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wake_req   <= 1'b0;
            rx_dma_req <= 1'b0;
            tx_dma_req <= 1'b0;
        end else begin
            wake_req   <= evt_flag_r && evt_en_r;
            rx_dma_req <= rx_store;
            tx_dma_req <= word_done;
        end
    end

    // Baud generator, cleared whenever the master is halted
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 9'h000;
        end else if (!on || halt || st_r != SSP_SHIFT || !master) begin
            div_r <= 9'h000;
        end else if (div_r >= div_max) begin
            div_r <= 9'h000;
        end else begin
            div_r <= div_r + 9'h001;
        end
    end
    assign tick = master && (st_r == SSP_SHIFT) && !halt && (div_r >= div_max);

    // Slave clock taken as synchronous; edges found against last sample
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sck_in_r <= 1'b0;
        end else begin
            sck_in_r <= shift_clock_pin_i;
        end
    end
    assign s_rise = shift_clock_pin_i && !sck_in_r;
    assign s_fall = !shift_clock_pin_i && sck_in_r;

    always_comb begin
        shift_edge  = 1'b0;
        sample_edge = 1'b0;
        if (master) begin
            sample_edge = tick && !ph_r;
            shift_edge  = tick && ph_r;
        end else if (!halt && !(con1_r.select_pin_enable && ss_n_i)) begin
            sample_edge = (con1_r.clock_polarity ^ con1_r.clock_edge) ? s_fall : s_rise;
            shift_edge  = (con1_r.clock_polarity ^ con1_r.clock_edge) ? s_rise : s_fall;
        end
    end

    assign tx_load   = (st_r == SSP_IDLE) && on && stat_r[STAT_TBF] && !bus_wr_buf
                       && !(master && halt);
    assign word_done = (st_r == SSP_DONE);
    // Only a word that really lands in the buffer counts as received
    assign rx_store  = word_done && !stat_r[STAT_ROV] && (!stat_r[STAT_RBF] || bus_rd_buf);

    // Shifter state machine
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r  <= SSP_IDLE;
            sr_r  <= REG_RESET;
            cnt_r <= 5'h00;
            ph_r  <= 1'b0;
            sck_r <= 1'b0;
        end else if (!on) begin
            st_r  <= SSP_IDLE;
            cnt_r <= 5'h00;
            ph_r  <= 1'b0;
            sck_r <= con1_r.clock_polarity;
        end else if (master && halt) begin
            st_r  <= SSP_IDLE;
            cnt_r <= 5'h00;
            ph_r  <= 1'b0;
            sck_r <= con1_r.clock_polarity;
        end else begin
            case (st_r)
                SSP_IDLE: begin
                    sck_r <= con1_r.clock_polarity;
                    if (tx_load) begin
                        sr_r  <= con1_r.word_width_select ? txbuf_r : {txbuf_r[7:0], 8'h00};
                        cnt_r <= 5'h00;
                        ph_r  <= 1'b0;
                        st_r  <= SSP_SHIFT;
                    end else if (!master) begin
                        // Slave listens with an empty buffer; a later write waits for word end
                        cnt_r <= 5'h00;
                        st_r  <= SSP_SHIFT;
                    end
                end
                SSP_SHIFT: begin
                    if (tick) begin
                        sck_r <= ~sck_r;
                        ph_r  <= ~ph_r;
                    end
                    if (sample_edge) begin
                        sr_r  <= {sr_r[14:0], sdi};
                        cnt_r <= cnt_r + 5'h01;
                    end
                    // Exactly nbits pulses per load; framed keeps clock running
                    if (shift_edge && cnt_r == nbits) begin
                        st_r <= SSP_DONE;
                    end else if (!master && sample_edge && cnt_r == nbits - 5'h01) begin
                        st_r <= SSP_DONE;
                    end
                end
                SSP_DONE: begin
                    if (!con1_r.word_width_select) begin
                        sr_r <= {8'h00, sr_r[7:0]};
                    end
                    st_r <= (framed && master && stat_r[STAT_TBF]) ? SSP_SHIFT : SSP_IDLE;
                    cnt_r <= 5'h00;
                    if (framed && master && stat_r[STAT_TBF]) begin
                        sr_r <= con1_r.word_width_select ? txbuf_r : {txbuf_r[7:0], 8'h00};
                    end
                end
                default: st_r <= SSP_IDLE;
            endcase
        end
    end

    // Pin drivers from flops; module off releases everything
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_clock_pin_o  <= 1'b0;
            shift_clock_pin_oe <= 1'b0;
            sdo                <= 1'b0;
            sdo_oe             <= 1'b0;
        end else begin
            shift_clock_pin_o  <= sck_r;
            shift_clock_pin_oe <= on && master && !con1_r.clock_output_disable;
            sdo                <= sr_r[15];
            sdo_oe             <= on && !con1_r.data_output_disable;
        end
    end
endmodule // ssp_top

// >>> tb/ssp_top_sva.sv
// Checker for the serial port bus, power-mode and link behaviour
`timescale 1ns/100ps
module ssp_top_chk (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        sleep_req,
    input wire logic        idle_req,
    input wire logic        wake_req,
    input wire logic        rx_dma_req,
    input wire logic        tx_dma_req,
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe,
    input wire logic        sdo_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic        dph_r, wr_r, on_r, idle_r, en_r, unread_r, sck_r;
    logic [31:0] a_r, zmask;
    logic [4:0]  rise_r;
    wire         acc   = hready && hsel && htrans[1];
    wire         wdone = dph_r && wr_r && hready;
    always_comb begin
        zmask = 32'hFFFF_FFFF;
        if (a_r == ssp_pkg::ADDR_STAT) zmask = {16'hFFFF, ~ssp_pkg::STAT_MASK};
        if (a_r == ssp_pkg::ADDR_CON1) zmask = {16'hFFFF, ~ssp_pkg::CON1_MASK};
        if (a_r == ssp_pkg::ADDR_CON2) zmask = {16'hFFFF, ~ssp_pkg::CON2_MASK};
        if (a_r == ssp_pkg::ADDR_BUF) zmask = 32'hFFFF_0000;
        if (a_r == ssp_pkg::ADDR_EVT) zmask = 32'hFFFF_FFFC;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dph_r <= 1'b0;
            wr_r  <= 1'b0;
            a_r   <= 32'h0000_0000;
        end else if (hready) begin
            dph_r <= acc;
            wr_r  <= hwrite;
            a_r   <= haddr;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            on_r   <= 1'b0;
            idle_r <= 1'b0;
            en_r   <= 1'b0;
        end else if (wdone) begin
            if (a_r == ssp_pkg::ADDR_STAT) on_r <= hwdata[ssp_pkg::STAT_ON];
            if (a_r == ssp_pkg::ADDR_STAT) idle_r <= hwdata[ssp_pkg::STAT_IDLE];
            if (a_r == ssp_pkg::ADDR_EVT) en_r <= hwdata[ssp_pkg::EVT_EN];
        end
    end
    // Cleared at the read's address phase, never later than the design
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) unread_r <= 1'b0;
        else if (rx_dma_req) unread_r <= 1'b1;
        else if (acc && !hwrite && haddr == ssp_pkg::ADDR_BUF) unread_r <= 1'b0;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sck_r  <= 1'b0;
            rise_r <= 5'h00;
        end else begin
            sck_r <= shift_clock_pin_o;
            if (tx_dma_req || sleep_req || !shift_clock_pin_oe) rise_r <= 5'h00;
            else if (shift_clock_pin_o && !sck_r) rise_r <= rise_r + 5'h01;
        end
    end
    read_zero_bits_a: assert property (dph_r && !wr_r && hready |-> (hrdata & zmask) == '0)
        else $error("reserved read bits not zero");
    wake_needs_en_a: assert property ($rose(wake_req) |-> en_r)
        else $error("wake raised without enable");
    wake_follows_a: assert property (rx_dma_req && en_r |-> ##[0:3] wake_req)
        else $error("wake missing after stored word");
    word_clocks_a: assert property ($rose(tx_dma_req) && shift_clock_pin_oe |-> rise_r == 5'h08 || rise_r == 5'h10)
        else $error("wrong clock pulse count per word");
    off_quiet_a: assert property (!on_r [*2] |-> !shift_clock_pin_oe && !sdo_oe)
        else $error("pins driven while module off");
    no_store_unread_a: assert property (rx_dma_req |-> !unread_r)
        else $error("word stored over unread buffer");
    idle_stops_a: assert property ((idle_r && idle_req && on_r) [*3] |-> !rx_dma_req && !tx_dma_req)
        else $error("traffic while idle halted");
    sleep_freeze_a: assert property ((sleep_req && shift_clock_pin_oe) [*3] |-> $stable(shift_clock_pin_o) && !tx_dma_req)
        else $error("master clock runs in sleep");
    cover property (wake_req);
    cover property (rx_dma_req && !shift_clock_pin_oe);
    cover property ($rose(tx_dma_req));
endmodule // ssp_top_chk
bind ssp_top ssp_top_chk u_ssp_top_chk (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .sleep_req(sleep_req), .idle_req(idle_req), .wake_req(wake_req),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_pin_oe(shift_clock_pin_oe), .sdo_oe(sdo_oe));

// >>> tb/ssp_peer.sv
// Link peer acting as serial master towards a slave-role port
`timescale 1ns/100ps
module ssp_peer (
    input  wire logic clk_sys,
    output logic      sck,
    output logic      sdi_d,
    output logic      ss_n
);
    logic tgl_r  = 1'b0;
    logic tx_bit = 1'b0;
    initial begin
        sck  = 1'b0;
        ss_n = 1'b1;
    end
    // Released data line toggles so a stale bit never looks valid
    always @(posedge clk_sys) begin
        tgl_r <= ~tgl_r;
        sdi_d <= ss_n ? tgl_r : tx_bit;
    end
    // Data held from well before the rise to well after the fall
    task automatic send(input logic [7:0] b);
        ss_n <= 1'b0;
        @(posedge clk_sys);
        for (int i = 7; i >= 0; i--) begin
            tx_bit <= b[i];
            repeat (4) @(posedge clk_sys);
            sck <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sck <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        ss_n <= 1'b1;
    endtask
endmodule // ssp_peer

// >>> tb/tb_ssp_top.sv
// Bench for the serial port: registers, master words, slave words, power modes
`timescale 1ns/100ps
module tb_ssp_top;
    logic        clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        sleep_req = 1'b0, idle_req = 1'b0, prev = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b000;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, wake_req, rx_dma_req, tx_dma_req, sck_o, sck_oe;
    wire         sdo, sdo_oe, peer_sck, peer_sdi, peer_ss_n;
    wire         sck_w = sck_oe ? sck_o : peer_sck;
    int          err_total = 0, samples_checked = 0, cyc = 0, last = 0, gap = 0;
    int          rises = 0, txp = 0, rxp = 0, r0, n;
    always #2.5 clk_sys = ~clk_sys;
    ssp_top u_ssp_top (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
        .idle_req(idle_req), .wake_req(wake_req), .rx_dma_req(rx_dma_req),
        .tx_dma_req(tx_dma_req), .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
        .shift_clock_pin_oe(sck_oe), .sdi(peer_sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .ss_n_i(peer_ss_n));
    ssp_peer u_ssp_peer (.clk_sys(clk_sys), .sck(peer_sck), .sdi_d(peer_sdi), .ss_n(peer_ss_n));
    // Sampled mid-cycle, clear of the edge that updates the outputs
    always @(negedge clk_sys) begin
        cyc++;
        prev <= sck_o;
        if (sck_o && !prev) begin
            rises++;
            gap = cyc - last;
            last = cyc;
        end
        if (tx_dma_req) txp++;
        if (rx_dma_req) rxp++;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= a;
        do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hsize <= 3'b000;
        hwdata <= d;
        do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 50);
        q = hrdata;
        if (k >= 50) begin err_total++; give_verdict(); end
    endtask
    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask
    task automatic wait_rx;
        n = 0;
        do begin bus(1'b0, ssp_pkg::ADDR_STAT, 32'h0000_0000); n++; end while (q[0] !== 1'b1 && n < 200);
        if (n >= 200) begin err_total++; give_verdict(); end
    endtask
    // Ratio 1 x 2 gives a bit period of four cycles
    task automatic master_word(input logic w16);
        bus(1'b1, ssp_pkg::ADDR_CON1, {21'h0, w16, 10'h03B});
        rises = 0;
        txp = 0;
        rxp = 0;
        bus(1'b1, ssp_pkg::ADDR_BUF, 32'h0000_005A);
        wait_rx;
        chk("clock pulses", w16 ? 32'h10 : 32'h08, rises);
        chk("bit period", 32'h4, gap);
        chk("tx dma", 32'h1, txp);
        chk("rx dma", 32'h1, rxp);
        bus(1'b0, ssp_pkg::ADDR_BUF, 32'h0000_0000);
        rd("status after read", ssp_pkg::ADDR_STAT, 32'h8000);
        $display("master word test done, width16 %0b", w16);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 6; i++) rd("reset value", 32'h4 * i, 32'h0);
        bus(1'b1, ssp_pkg::ADDR_CON1, 32'hFFFF_FFFF);
        rd("control one", ssp_pkg::ADDR_CON1, 32'h1FFF);
        bus(1'b1, ssp_pkg::ADDR_CON2, 32'hFFFF_FFFF);
        rd("control two", ssp_pkg::ADDR_CON2, 32'hE002);
        bus(1'b1, ssp_pkg::ADDR_STAT, 32'hFFFF_FFFF);
        rd("status", ssp_pkg::ADDR_STAT, 32'hA000);
        bus(1'b1, ssp_pkg::ADDR_CON2, 32'h0);
        bus(1'b1, ssp_pkg::ADDR_STAT, 32'h8000);
        $display("register test done");
        master_word(1'b0);
        master_word(1'b1);
        rises = 0;
        bus(1'b1, ssp_pkg::ADDR_BUF, 32'h0000_00C3);
        n = 0;
        while (rises < 3 && n < 100) begin @(posedge clk_sys); n++; end
        sleep_req <= 1'b1;
        r0 = rises;
        repeat (20) @(posedge clk_sys);
        chk("clocks in sleep", r0, rises);
        sleep_req <= 1'b0;
        repeat (60) @(posedge clk_sys);
        chk("clocks after wake", r0, rises);
        rd("aborted status", ssp_pkg::ADDR_STAT, 32'h8000);
        rd("kept control", ssp_pkg::ADDR_CON1, 32'h043B);
        master_word(1'b0);
        $display("master sleep test done");
        bus(1'b1, ssp_pkg::ADDR_CON1, 32'h0);
        bus(1'b1, ssp_pkg::ADDR_EVT, 32'h2);
        sleep_req <= 1'b1;
        u_ssp_peer.send(8'h3C);
        repeat (4) @(posedge clk_sys);
        chk("wake", 32'h1, wake_req);
        rd("slave status", ssp_pkg::ADDR_STAT, 32'h8001);
        sleep_req <= 1'b0;
        rd("slave word", ssp_pkg::ADDR_BUF, 32'h3C);
        rd("event", ssp_pkg::ADDR_EVT, 32'h3);
        bus(1'b1, ssp_pkg::ADDR_EVT, 32'h2);
        repeat (3) @(posedge clk_sys);
        chk("wake cleared", 32'h0, wake_req);
        $display("slave sleep test done");
        u_ssp_peer.send(8'h11);
        u_ssp_peer.send(8'h22);
        rd("overrun status", ssp_pkg::ADDR_STAT, 32'h8041);
        rd("kept word", ssp_pkg::ADDR_BUF, 32'h11);
        bus(1'b1, ssp_pkg::ADDR_STAT, 32'h8000);
        rd("overrun cleared", ssp_pkg::ADDR_STAT, 32'h8000);
        u_ssp_peer.send(8'h33);
        rd("word after clear", ssp_pkg::ADDR_BUF, 32'h33);
        $display("overrun test done");
        bus(1'b1, ssp_pkg::ADDR_STAT, 32'hA000);
        idle_req <= 1'b1;
        u_ssp_peer.send(8'h44);
        rd("idle halted", ssp_pkg::ADDR_STAT, 32'hA000);
        bus(1'b1, ssp_pkg::ADDR_STAT, 32'h8000);
        u_ssp_peer.send(8'h55);
        rd("idle running", ssp_pkg::ADDR_BUF, 32'h55);
        idle_req <= 1'b0;
        chk("data enable on", 32'h1, sdo_oe);
        bus(1'b1, ssp_pkg::ADDR_STAT, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("data enable off", 32'h0, sdo_oe);
        $display("idle and off test done");
        give_verdict();
    end
endmodule // tb_ssp_top
